// ### plc_link_regs.sv
// Link capability, control and status registers of the non-transparent downstream port
`timescale 1ns/10ps
`include "plc_params.svh"
module plc_link_regs
  import plc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Configuration access, registered answer one cycle later
  input wire logic i_cfg_rd,
  input wire logic i_cfg_wr,
  input wire logic [11:0] i_cfg_addr,
  input wire logic [3:0] i_cfg_be,
  input wire logic [31:0] i_cfg_wdata,
  output logic o_cfg_ack,
  output logic [31:0] o_cfg_rdata,
  // Serial EEPROM loader writes, bypass the lock
  input wire logic i_ee_wr,
  input wire logic [11:0] i_ee_addr,
  input wire logic [31:0] i_ee_wdata,
  // Lock and mode inputs from the switch core
  input wire logic i_reg_unlock,
  input wire logic i_deep_d3_disable,
  input wire logic i_deep_l1_disable,
  input wire logic i_slot_clock,
  // Physical layer
  input wire logic i_train_active,
  input wire logic i_train_done,
  input wire logic i_train_error,
  input wire logic i_l0s_exit,
  input wire logic [7:0] i_nfts,
  input wire logic i_os_rdy,
  output logic o_retrain,
  output logic [5:0] o_link_width,
  output logic [1:0] o_aspm_ctrl,
  output logic o_link_training_flag,
  output logic o_fts_send,
  output logic o_skp_send
);
  plc_state_s q_ff;
  plc_state_s nxt_q;
  plc_cfg_req_s req;
  logic [31:0] cap_word;
  logic [31:0] ctl_word;
  logic [31:0] wmask;
  logic lock_open;
  logic fts_busy;

  // Reserved width codes fall back to a single lane
  function automatic logic [5:0] eff_width_f(input logic [5:0] code);
    case (code)
      `PLC_WIDTH_X1, `PLC_WIDTH_X2, `PLC_WIDTH_X4: eff_width_f = code;
      default: eff_width_f = `PLC_WIDTH_X1;
    endcase
  endfunction : eff_width_f

  // Byte enables widened to a bit mask
  function automatic logic [31:0] be_mask_f(input logic [3:0] be);
    be_mask_f = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : be_mask_f

  // Merge written bits under a mask
  function automatic logic [31:0] merge_f(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [31:0] m);
    merge_f = (old & ~m) | (wd & m);
  endfunction : merge_f

  // EEPROM loads take precedence and write whole words
  always_comb begin
    req.rd = i_cfg_rd & ~i_ee_wr;
    req.wr = i_cfg_wr | i_ee_wr;
    req.ee = i_ee_wr;
    req.addr = i_ee_wr ? i_ee_addr : i_cfg_addr;
    req.be = i_ee_wr ? 4'hF : i_cfg_be;
    req.wdata = i_ee_wr ? i_ee_wdata : i_cfg_wdata;
  end

  assign lock_open = i_reg_unlock | req.ee;
  assign wmask = be_mask_f(req.be);

  // Capability word: fixed speed and support, latencies from live modes
  always_comb begin
    cap_word = 32'h0000_0000;
    cap_word[3:0] = `PLC_MAX_SPEED_CODE;
    cap_word[9:4] = q_ff.max_width;
    cap_word[11:10] = `PLC_ASPM_SUPPORT;
    cap_word[14:12] = q_ff.common_clock_config ? `PLC_L0S_LAT_COMMON : `PLC_L0S_LAT_SEP;
    cap_word[17:15] = (i_deep_d3_disable | i_deep_l1_disable) ?
                      `PLC_L1_LAT_DEEP : `PLC_L1_LAT_NORMAL;
    cap_word[31:24] = q_ff.port_num;
  end

  // Control in the low half, status in the high half
  always_comb begin
    ctl_word = 32'h0000_0000;
    ctl_word[1:0] = q_ff.aspm;
    ctl_word[3] = 1'b0;
    ctl_word[`PLC_CTL_LINK_DISABLE_BIT] = q_ff.link_dis;
    ctl_word[`PLC_CTL_RETRAIN_BIT] = 1'b0;
    ctl_word[`PLC_CTL_COMMON_CLOCK_CONFIG_BIT] = q_ff.common_clock_config;
    ctl_word[`PLC_CTL_EXTENDED_SYNC_BIT] = q_ff.extended_sync;
    ctl_word[19:16] = `PLC_MAX_SPEED_CODE;
    ctl_word[25:20] = q_ff.eff_width;
    ctl_word[26] = i_train_error;
    ctl_word[`PLC_STS_TRAIN_BIT] = q_ff.train_flag;
    ctl_word[28] = i_slot_clock;
  end

  // Next-state of the whole bank
  always_comb begin
    logic [31:0] m;
    m = 32'h0000_0000;
    nxt_q = q_ff;
    nxt_q.ack = req.rd | req.wr;
    nxt_q.retrain = 1'b0;
    nxt_q.rdata = 32'h0000_0000;
    if (req.rd) begin
      case (req.addr)
        `PLC_OFS_LINK_CAP: nxt_q.rdata = cap_word;
        `PLC_OFS_LINK_CTL: nxt_q.rdata = ctl_word;
        default: nxt_q.rdata = 32'h0000_0000;
      endcase
    end
    if (req.wr && req.addr == `PLC_OFS_LINK_CAP && lock_open) begin
      m = merge_f(cap_word, req.wdata, wmask);
      nxt_q.max_width = m[9:4];
      nxt_q.port_num = m[31:24];
    end
    if (req.wr && req.addr == `PLC_OFS_LINK_CTL) begin
      m = merge_f(ctl_word, req.wdata, wmask);
      nxt_q.aspm = m[1:0];
      nxt_q.link_dis = m[`PLC_CTL_LINK_DISABLE_BIT];
      nxt_q.common_clock_config = m[`PLC_CTL_COMMON_CLOCK_CONFIG_BIT];
      nxt_q.extended_sync = m[`PLC_CTL_EXTENDED_SYNC_BIT];
      // Retrain is a strobe only; nothing of it is stored
      if (req.be[0] && req.wdata[`PLC_CTL_RETRAIN_BIT]) begin
        nxt_q.retrain = 1'b1;
      end
    end
    // A new retrain request wins over a done in the same cycle
    if (nxt_q.retrain) begin
      nxt_q.train_pend = 1'b1;
    end else if (i_train_done) begin
      nxt_q.train_pend = 1'b0;
    end
    nxt_q.train_flag = nxt_q.train_pend | i_train_active;
    nxt_q.eff_width = eff_width_f(nxt_q.max_width);
  end

  // Single register stage for all state
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q_ff <= '{max_width: `PLC_WIDTH_RST, port_num: `PLC_PORT_NUM_RST,
                aspm: `PLC_ASPM_RST, link_dis: 1'b0, common_clock_config: 1'b0,
                extended_sync: 1'b0, train_pend: 1'b0, train_flag: 1'b0, retrain: 1'b0,
                ack: 1'b0, rdata: 32'h0000_0000, eff_width: `PLC_WIDTH_RST};
    end else begin
      q_ff <= nxt_q;
    end
  end

  // Link disable deliberately reaches no link output, only the read data: the virtual link has no LTSSM
  assign o_cfg_ack = q_ff.ack;
  assign o_cfg_rdata = q_ff.rdata;
  assign o_retrain = q_ff.retrain;
  assign o_link_width = q_ff.eff_width;
  assign o_aspm_ctrl = q_ff.aspm;
  assign o_link_training_flag = q_ff.train_flag;

  // FTS burst on L0s exit, length from extended sync
  plc_fts_seq u_fts (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_start(i_l0s_exit & ~fts_busy),
    .i_ext_sync(q_ff.extended_sync),
    .i_nfts(i_nfts),
    .i_os_rdy(i_os_rdy),
    .o_fts(o_fts_send),
    .o_skp(o_skp_send),
    .o_busy(fts_busy)
  );

  // Speed field read back fixed
  speed_fixed_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_cfg_rd && !i_ee_wr && i_cfg_addr == 12'h04C) |=> o_cfg_rdata[3:0] == 4'h1)
    else $error("max link speed not 0x1");

  // Only valid widths reach the link
  width_fallback_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_link_width == 6'h01 || o_link_width == 6'h02 || o_link_width == 6'h04)
    else $error("invalid link width driven");

  // Locked writes leave capability fields alone
  cap_lock_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_cfg_wr && !i_ee_wr && !i_reg_unlock && i_cfg_addr == 12'h04C)
      |=> $stable(q_ff.max_width) && $stable(q_ff.port_num))
    else $error("locked capability field changed");

  // Support field fixed at L0s
  aspm_support_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_cfg_rd && !i_ee_wr && i_cfg_addr == 12'h04C) |=> o_cfg_rdata[11:10] == 2'h1)
    else $error("ASPM support not L0s only");

  // L0s latency follows the common clock bit
  l0s_latency_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_cfg_rd && !i_ee_wr && i_cfg_addr == 12'h04C && !i_cfg_wr)
      |=> o_cfg_rdata[14:12] == ($past(q_ff.common_clock_config) ? 3'h3 : 3'h5))
    else $error("L0s exit latency wrong");

  // L1 latency follows the deep modes
  l1_latency_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_cfg_rd && !i_ee_wr && i_cfg_addr == 12'h04C)
      |=> o_cfg_rdata[17:15] ==
          (($past(i_deep_d3_disable) || $past(i_deep_l1_disable)) ? 3'h0 : 3'h4))
    else $error("L1 exit latency wrong");

  // Retrain and completion boundary never read as one
  ctl_zero_bits_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_cfg_rd && !i_ee_wr && i_cfg_addr == 12'h050)
      |=> o_cfg_rdata[5] == 1'b0 && o_cfg_rdata[3] == 1'b0)
    else $error("retrain or RCB read as one");

  // Retrain write gives one strobe and raises training; a write right behind may strobe again
  retrain_pulse_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    ((i_cfg_wr && !i_ee_wr && i_cfg_addr == 12'h050 && i_cfg_be[0] && i_cfg_wdata[5])
      ##1 !(i_cfg_wr || i_ee_wr)) |-> (o_retrain && o_link_training_flag ##1 !o_retrain))
    else $error("retrain strobe missing");

  // Training flag holds until done
  train_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (q_ff.train_pend && !i_train_done) |=> o_link_training_flag)
    else $error("training flag dropped early");

  // Every access answered next cycle
  cfg_ack_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_cfg_rd || i_cfg_wr) |=> o_cfg_ack)
    else $error("access not acknowledged");

  // Control bits read back as stored; read-only and reserved bits stay zero
  ctl_readback_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_cfg_rd && !i_ee_wr && i_cfg_addr == 12'h050)
      |=> o_cfg_rdata[15:0] == {8'h00, $past(q_ff.extended_sync), $past(q_ff.common_clock_config), 1'b0,
                                $past(q_ff.link_dis), 2'h0, $past(q_ff.aspm)})
    else $error("link control read back wrong");

  // Status half shows fixed speed, effective width and the training flag
  ctl_status_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_cfg_rd && !i_ee_wr && i_cfg_addr == 12'h050)
      |=> o_cfg_rdata[19:16] == 4'h1 && o_cfg_rdata[25:20] == $past(o_link_width)
          && o_cfg_rdata[27] == $past(o_link_training_flag))
    else $error("link status half wrong");

  // Unlocked width write is kept as written
  width_store_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_cfg_wr && !i_ee_wr && i_reg_unlock && i_cfg_addr == 12'h04C
      && i_cfg_be[1:0] == 2'h3) |=> q_ff.max_width == $past(i_cfg_wdata[9:4]))
    else $error("unlocked width write lost");

  // Unlocked port number write is kept as written
  port_store_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_cfg_wr && !i_ee_wr && i_reg_unlock && i_cfg_addr == 12'h04C && i_cfg_be[3])
      |=> q_ff.port_num == $past(i_cfg_wdata[31:24]))
    else $error("unlocked port number write lost");

  // Written ASPM code reaches the link controls
  aspm_write_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_cfg_wr && !i_ee_wr && i_cfg_addr == 12'h050 && i_cfg_be[0])
      |=> o_aspm_ctrl == $past(i_cfg_wdata[1:0]))
    else $error("ASPM control write lost");

  // EEPROM load overrides the ASPM default whatever the lock
  ee_aspm_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ee_wr && i_ee_addr == 12'h050) |=> o_aspm_ctrl == $past(i_ee_wdata[1:0]))
    else $error("EEPROM ASPM load lost");

  // Physical layer training keeps the flag up
  train_active_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_train_active |=> o_link_training_flag)
    else $error("training flag low while training");

  // A retrain strobe only ever follows a retrain write
  retrain_cause_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_retrain |-> $past(req.wr && req.addr == 12'h050 && req.be[0] && req.wdata[5]))
    else $error("retrain strobe without request");

  // Link disable and other control writes without retrain keep the link width and raise no retrain strobe
  link_disable_quiet_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (req.wr && req.addr == 12'h050 && !req.wdata[5])
      |=> $stable(o_link_width) && !o_retrain)
    else $error("control write disturbed the link");

  // Read data is zero outside read answers
  rdata_idle_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !req.rd |=> o_cfg_rdata == 32'h0000_0000)
    else $error("read data outside a read answer");
endmodule : plc_link_regs

// ### plc_params.svh
// Offsets, field positions, reset values and codes for the link capability/control registers
`ifndef PLC_PARAMS_SVH
`define PLC_PARAMS_SVH

`define PLC_OFS_LINK_CAP 12'h04C
`define PLC_OFS_LINK_CTL 12'h050

`define PLC_MAX_SPEED_CODE 4'h1
`define PLC_WIDTH_X1 6'h01
`define PLC_WIDTH_X2 6'h02
`define PLC_WIDTH_X4 6'h04
`define PLC_WIDTH_RST 6'h04
`define PLC_ASPM_SUPPORT 2'h1
`define PLC_L0S_LAT_SEP 3'h5
`define PLC_L0S_LAT_COMMON 3'h3
`define PLC_L1_LAT_DEEP 3'h0
`define PLC_L1_LAT_NORMAL 3'h4
`define PLC_PORT_NUM_RST 8'h02
`define PLC_ASPM_RST 2'h0

`define PLC_CAP_WIDTH_LSB 4
`define PLC_CAP_PORT_LSB 24
`define PLC_CTL_LINK_DISABLE_BIT 4
`define PLC_CTL_RETRAIN_BIT 5
`define PLC_CTL_COMMON_CLOCK_CONFIG_BIT 6
`define PLC_CTL_EXTENDED_SYNC_BIT 7
`define PLC_STS_TRAIN_BIT 27

`define PLC_FTS_EXT_COUNT 13'h1000
`endif

// ### plc_pkg.sv
// Types shared by the link register bank and its FTS sequencer
package plc_pkg;
  // Configuration access from the switch core or the EEPROM loader
  typedef struct packed {
    logic rd;
    logic wr;
    logic ee;
    logic [11:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } plc_cfg_req_s;

  // All state of the register bank
  typedef struct packed {
    logic [5:0] max_width;
    logic [7:0] port_num;
    logic [1:0] aspm;
    logic link_dis;
    logic common_clock_config;
    logic extended_sync;
    logic train_pend;
    logic train_flag;
    logic retrain;
    logic ack;
    logic [31:0] rdata;
    logic [5:0] eff_width;
  } plc_state_s;

  typedef enum logic [1:0] {PLC_FTS_IDLE, PLC_FTS_SEND, PLC_FTS_SKP} plc_fts_e;

  // All state of the FTS sequencer
  typedef struct packed {
    plc_fts_e st;
    logic [12:0] cnt;
    logic fts;
    logic skp;
  } plc_fts_s;
endpackage : plc_pkg

// ### plc_fts_seq.sv
// FTS ordered-set sequencer for L0s exit
`timescale 1ns/10ps
`include "plc_params.svh"
module plc_fts_seq
  import plc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Control
  input wire logic i_start,
  input wire logic i_ext_sync,
  input wire logic [7:0] i_nfts,
  input wire logic i_os_rdy,
  // Ordered set strobes and busy flag
  output logic o_fts,
  output logic o_skp,
  output logic o_busy
);
  plc_fts_s q_ff;
  plc_fts_s nxt_q;

  // One ordered set per transmitter-ready cycle; SKP closes the burst
  always_comb begin
    nxt_q = q_ff;
    nxt_q.fts = 1'b0;
    nxt_q.skp = 1'b0;
    case (q_ff.st)
      PLC_FTS_IDLE: begin
        if (i_start) begin
          nxt_q.st = PLC_FTS_SEND;
          nxt_q.cnt = i_ext_sync ? `PLC_FTS_EXT_COUNT : {5'h00, i_nfts};
        end
      end
      PLC_FTS_SEND: begin
        if (q_ff.cnt == 13'h0000) begin
          nxt_q.st = PLC_FTS_SKP;
        end else if (i_os_rdy) begin
          nxt_q.fts = 1'b1;
          nxt_q.cnt = q_ff.cnt - 13'h0001;
        end
      end
      PLC_FTS_SKP: begin
        if (i_os_rdy) begin
          nxt_q.skp = 1'b1;
          nxt_q.st = PLC_FTS_IDLE;
        end
      end
      default: nxt_q.st = PLC_FTS_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q_ff <= '{st: PLC_FTS_IDLE, cnt: 13'h0000, fts: 1'b0, skp: 1'b0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign o_fts = q_ff.fts;
  assign o_skp = q_ff.skp;
  assign o_busy = (q_ff.st != PLC_FTS_IDLE);

  // Extended burst loads the full count
  ext_count_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (q_ff.st == PLC_FTS_IDLE && i_start && i_ext_sync) |=> q_ff.cnt == 13'h1000)
    else $error("extended sync count not loaded");
endmodule : plc_fts_seq

// ### plc_phy_model.sv
// Physical layer and transmitter model facing the link register bank
`timescale 1ns/10ps
module plc_phy_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // From the register bank and bench
  input wire logic i_retrain,
  input wire logic i_slow,
  // To the register bank
  output logic o_train_active,
  output logic o_train_done,
  output logic o_os_rdy
);
  logic [3:0] cnt_ff;
  logic [1:0] ph_ff;
  // Recovery runs eight cycles, then one done pulse
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_ff <= 4'h0;
      ph_ff <= 2'h0;
      o_train_done <= 1'b0;
    end else begin
      ph_ff <= ph_ff + 2'h1;
      o_train_done <= (cnt_ff == 4'h1);
      if (i_retrain) begin
        cnt_ff <= 4'h8;
      end else if (cnt_ff != 4'h0) begin
        cnt_ff <= cnt_ff - 4'h1;
      end
    end
  end
  // Slow mode stalls one cycle in four, so the burst must wait on ready
  assign o_train_active = (cnt_ff != 4'h0);
  assign o_os_rdy = !i_slow || (ph_ff != 2'h0);
endmodule : plc_phy_model

// ### tb_top.sv
// Self-checking bench for the link capability and control registers
`timescale 1ns/10ps
`include "plc_params.svh"
module tb_top;
  logic clk, nrst, rd, wr, ack, ee_wr, unlock, d3, l1d, tr_act, tr_done, os_rdy;
  logic l0s_exit, retrain, tflag, fts, skp, slow;
  logic [11:0] addr, ee_addr;
  logic [3:0] be;
  logic [31:0] wdata, rdata, ee_wdata, rv;
  logic [7:0] nfts;
  logic [5:0] width;
  logic [1:0] aspm;
  int err_total, compares, cyc;
  plc_link_regs dut (.i_clk(clk), .i_nrst(nrst), .i_cfg_rd(rd), .i_cfg_wr(wr),
    .i_cfg_addr(addr), .i_cfg_be(be), .i_cfg_wdata(wdata), .o_cfg_ack(ack),
    .o_cfg_rdata(rdata), .i_ee_wr(ee_wr), .i_ee_addr(ee_addr), .i_ee_wdata(ee_wdata),
    .i_reg_unlock(unlock), .i_deep_d3_disable(d3), .i_deep_l1_disable(l1d),
    .i_slot_clock(1'b0), .i_train_active(tr_act), .i_train_done(tr_done),
    .i_train_error(1'b0), .i_l0s_exit(l0s_exit), .i_nfts(nfts), .i_os_rdy(os_rdy),
    .o_retrain(retrain), .o_link_width(width), .o_aspm_ctrl(aspm),
    .o_link_training_flag(tflag), .o_fts_send(fts), .o_skp_send(skp));
  plc_phy_model phy (.i_clk(clk), .i_nrst(nrst), .i_retrain(retrain), .i_slow(slow),
    .o_train_active(tr_act), .o_train_done(tr_done), .o_os_rdy(os_rdy));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One access; ack and read data stand only in the cycle after the request edge
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(negedge clk);
    rd = !w;
    wr = w;
    addr = a;
    wdata = d;
    @(negedge clk);
    chk(ack, 1'b1);
    rv = rdata;
    rd = 1'b0;
    wr = 1'b0;
  endtask : acc
  function automatic logic [31:0] cap_exp(input logic [5:0] w, input logic [7:0] p,
                                          input logic cc, input logic dp);
    cap_exp = {p, 6'h00, (dp ? `PLC_L1_LAT_DEEP : `PLC_L1_LAT_NORMAL),
      (cc ? `PLC_L0S_LAT_COMMON : `PLC_L0S_LAT_SEP), `PLC_ASPM_SUPPORT, w,
      `PLC_MAX_SPEED_CODE};
  endfunction : cap_exp
  task automatic t_reset;
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    acc(1'b0, `PLC_OFS_LINK_CAP, 32'h0);
    chk(rv, cap_exp(`PLC_WIDTH_RST, `PLC_PORT_NUM_RST, 1'b0, 1'b0));
    acc(1'b0, `PLC_OFS_LINK_CTL, 32'h0);
    chk(rv[15:0], 16'h0000);
    chk(width, `PLC_WIDTH_X4);
  endtask : t_reset
  // Lock closed, then open; reserved widths fall back to x1
  task automatic t_lock;
    logic [5:0] codes [4] = '{6'h00, 6'h03, 6'h05, 6'h08};
    acc(1'b1, `PLC_OFS_LINK_CAP, 32'hFFFF_FFFF);
    acc(1'b0, `PLC_OFS_LINK_CAP, 32'h0);
    chk(rv, cap_exp(6'h04, 8'h02, 1'b0, 1'b0));
    unlock = 1'b1;
    acc(1'b1, `PLC_OFS_LINK_CAP, 32'h07FF_FC2F);
    acc(1'b0, `PLC_OFS_LINK_CAP, 32'h0);
    chk(rv, cap_exp(`PLC_WIDTH_X2, 8'h07, 1'b0, 1'b0));
    chk(width, `PLC_WIDTH_X2);
    foreach (codes[i]) begin
      acc(1'b1, `PLC_OFS_LINK_CAP, {8'h02, 14'h0000, codes[i], 4'h0});
      @(posedge clk);
      #1;
      chk(width, `PLC_WIDTH_X1);
    end
    acc(1'b1, `PLC_OFS_LINK_CAP, 32'h0200_0040);
    unlock = 1'b0;
  endtask : t_lock
  // Every ASPM code with the other writable bits set and RCB written one
  task automatic t_ctl;
    for (int a = 0; a < 4; a++) begin
      acc(1'b1, `PLC_OFS_LINK_CTL, 32'h0000_00D8 | a);
      acc(1'b0, `PLC_OFS_LINK_CTL, 32'h0);
      chk(rv[15:0], 16'h00D0 | a);
      chk(aspm, a[1:0]);
    end
    acc(1'b0, `PLC_OFS_LINK_CAP, 32'h0);
    chk(rv, cap_exp(6'h04, 8'h02, 1'b1, 1'b0));
    chk(width, `PLC_WIDTH_X4);
  endtask : t_ctl
  task automatic t_retrain;
    acc(1'b1, `PLC_OFS_LINK_CTL, 32'h0000_0020);
    chk(retrain, 1'b1);
    chk(tflag, 1'b1);
    acc(1'b0, `PLC_OFS_LINK_CTL, 32'h0);
    chk(rv[5], 1'b0);
    chk(rv[`PLC_STS_TRAIN_BIT], 1'b1);
    for (int i = 0; i < 30 && tflag !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    chk(tflag, 1'b0);
  endtask : t_retrain
  task automatic t_deep;
    @(negedge clk);
    l1d = 1'b1;
    acc(1'b0, `PLC_OFS_LINK_CAP, 32'h0);
    chk(rv, cap_exp(6'h04, 8'h02, 1'b0, 1'b1));
    l1d = 1'b0;
    d3 = 1'b1;
    acc(1'b0, `PLC_OFS_LINK_CAP, 32'h0);
    chk(rv, cap_exp(6'h04, 8'h02, 1'b0, 1'b1));
    d3 = 1'b0;
  endtask : t_deep
  // Count FTS strobes until the closing SKP
  task automatic t_fts(input logic ext, input int exp);
    int n;
    logic seen;
    n = 0;
    seen = 1'b0;
    acc(1'b1, `PLC_OFS_LINK_CTL, {24'h0, ext, 7'h00});
    @(negedge clk);
    l0s_exit = 1'b1;
    @(negedge clk);
    l0s_exit = 1'b0;
    for (int i = 0; i < 6000 && !seen; i++) begin
      @(posedge clk);
      #1;
      if (fts === 1'b1) n++;
      if (skp === 1'b1) seen = 1'b1;
    end
    chk(n, exp);
    chk(seen, 1'b1);
  endtask : t_fts
  // EEPROM load overrides the ASPM default
  task automatic t_ee;
    @(negedge clk);
    ee_wr = 1'b1;
    ee_addr = `PLC_OFS_LINK_CTL;
    ee_wdata = 32'h0000_0003;
    @(negedge clk);
    chk(ack, 1'b1);
    chk(aspm, 2'h3);
    ee_wr = 1'b0;
  endtask : t_ee
  task close_out;
    $display("err_total=%0d compares=%0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out
  initial begin
    {nrst, rd, wr, ee_wr, unlock, d3, l1d, l0s_exit, slow} = '0;
    {addr, ee_addr, wdata, ee_wdata} = '0;
    be = 4'hF;
    nfts = 8'h05;
    t_reset();
    t_lock();
    t_ctl();
    t_retrain();
    t_deep();
    slow = 1'b1;
    t_fts(1'b1, 4096);
    slow = 1'b0;
    t_fts(1'b0, 5);
    t_ee();
    t_reset();
    close_out();
  end
endmodule : tb_top
